// ---- hdl/sflash_cmd.sv ----
// Purpose: Serial flash command decoder and operation timer.
// Assumes: Link pins are sampled by ref_clk; link clock well below 10 MHz.
// Notes: Array is a small model; upper address bits are ignored.
// How it works
// - Array starts with every byte reading FFh.
// - Status register starts at 00h.
// - Write-type instructions refused for lockout after power-up; host waits maximum.
// - Opcode 04h clears write permission.
// - Opcode 01h writes bits 7:2 of the following status byte; bits 1:0 read back 0.
// - Opcode 03h takes address, then streams array bytes.
// - Opcode 20h erases the addressed sector.
// - Opcodes 52h and D8h both erase the addressed block.
// - Opcodes 60h and C7h both erase the whole array.
// - Opcode B9h enters deep power-down.
// - Opcode ABh wakes and returns the signature byte.
// - Identification read address 00h gives maker first, 01h device first.
// - Status write keeps the device busy for the status write time.
// - Deep power-down reached within 3 us of select rising.
// - Standby reached within 3 us after wake.
// - Page program keeps device busy for its program time.
// - Sector erase keeps device busy for its erase time.
`timescale 1ns/1ps
`default_nettype none
module sflash_cmd #(
  parameter int unsigned LOCKOUT_CYC = sflash_pkg::WRITE_LOCKOUT_CYC,
  parameter int unsigned STATUS_CYC = sflash_pkg::STATUS_WRITE_CYC,
  parameter int unsigned PROG_CYC = sflash_pkg::PAGE_PROGRAM_CYC,
  parameter int unsigned SECTOR_CYC = sflash_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned BLOCK_CYC = sflash_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_CYC = sflash_pkg::CHIP_ERASE_CYC,
  parameter logic [7:0] MFR_CODE = 8'hA5,
  parameter logic [7:0] DEV_CODE = 8'h3C
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  output logic busy,
  output logic sleeping,
  output logic lockout
);
  import sflash_pkg::*;
  // MFR_CODE and DEV_CODE values are arbitrary

  // ==========================================================
  // Pin synchronisers
  logic [2:0] s1, s2;
  logic cs_q, sclk_q;
  always_ff @(posedge ref_clk) begin
    s1 <= {cs_n, sclk, si};
    s2 <= s1;
    sclk_q <= s2[1];
    cs_q <= s2[2];
  end
  wire sel_n = s2[2];
  wire sck_rise = s2[1] & ~sclk_q;
  wire sck_fall = ~s2[1] & sclk_q;
  wire sel_rise = s2[2] & ~cs_q;
  wire sel_fall = ~s2[2] & cs_q;

  function automatic logic is_write_op(input logic [7:0] op);
    is_write_op = (op == OP_STATUS_WRITE) || (op == OP_PAGE_PROG) || (op == OP_SECTOR_ERASE) ||
                  (op == OP_BLOCK_ERASE_A) || (op == OP_BLOCK_ERASE_B) ||
                  (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B) || (op == OP_WRITE_ENABLE);
  endfunction : is_write_op

  // ==========================================================
  // Serial shift-in
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [7:0] opcode;
  logic [5:0] bytecnt;
  logic [ADDR_W-1:0] addr;
  logic [7:0] data_byte;
  wire [7:0] next_byte = {shreg[6:0], s2[0]};
  wire byte_done = ~sel_n & sck_rise & (bitcnt == 3'd7);
  always_ff @(posedge ref_clk) begin
    if (!resetn || sel_fall) begin
      bitcnt <= 3'd0;
      bytecnt <= 6'd0;
      shreg <= 8'h00;
    end else if (~sel_n & sck_rise) begin
      shreg <= next_byte;
      bitcnt <= bitcnt + 3'd1;
      if (bitcnt == 3'd7 && bytecnt != 6'h3F) begin
        bytecnt <= bytecnt + 6'd1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      opcode <= 8'h00;
      addr <= '0;
      data_byte <= 8'h00;
    end else if (byte_done) begin
      if (bytecnt == 6'd0) begin
        opcode <= next_byte;
      end else if (bytecnt <= 6'd3) begin
        addr <= {addr[ADDR_W-9:0], next_byte};
      end
      if (bytecnt == 6'd1) begin
        data_byte <= next_byte;
      end
    end
  end

  // ==========================================================
  // Power-up lockout, sleep and write latch
  logic [CNT_W-1:0] lock_cnt;
  logic [7:0] status;
  logic sleep_pend, wake_pend;
  logic [7:0] pend_cnt;
  // Synchroniser lag from the select pin to cmd_end; the sleep and wake counts
  // give it back so that the limit still holds when measured at the pin.
  localparam int unsigned PIN_LAG = 3;
  wire cmd_end = sel_rise;
  wire write_ok = ~lockout & ~busy & ~sleeping;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lock_cnt <= CNT_W'(LOCKOUT_CYC);
      lockout <= 1'b1;
    end else if (lock_cnt != '0) begin
      lock_cnt <= lock_cnt - CNT_W'(1);
    end else begin
      lockout <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sleeping <= 1'b0;
      sleep_pend <= 1'b0;
      wake_pend <= 1'b0;
      pend_cnt <= 8'h00;
    end else if (sleep_pend | wake_pend) begin
      if (pend_cnt == 8'h00) begin
        sleeping <= sleep_pend;
        sleep_pend <= 1'b0;
        wake_pend <= 1'b0;
      end else begin
        pend_cnt <= pend_cnt - 8'h01;
      end
    end else if (cmd_end && bytecnt != 6'd0) begin
      // Wake also when the host stays selected to read the signature
      if (opcode == OP_WAKE_SIG && sleeping) begin
        wake_pend <= 1'b1;
        pend_cnt <= 8'(WAKE_CYC - PIN_LAG - 1);
      end else if (opcode == OP_DEEP_SLEEP && bytecnt == 6'd1 && !sleeping && !busy) begin
        sleep_pend <= 1'b1;
        pend_cnt <= 8'(SLEEP_ENTRY_CYC - PIN_LAG - 1);
      end
    end
  end

  // ==========================================================
  // Self-timed operations
  logic [CNT_W-1:0] op_cnt;
  op_kind_t op_kind;
  logic [MEM_AW-1:0] er_ptr, er_last;
  logic [7:0] new_status;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  wire erase_walk = busy & (op_kind == OPK_ERASE) & (er_ptr != er_last);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      op_cnt <= '0;
      op_kind <= OPK_STATUS;
      er_ptr <= '0;
      er_last <= '0;
      new_status <= STATUS_RESET;
      status <= STATUS_RESET;
    end else if (busy) begin
      if (erase_walk) begin
        er_ptr <= er_ptr + MEM_AW'(1);
      end
      if (op_cnt == '0) begin
        busy <= 1'b0;
        status[STAT_WEL] <= 1'b0;
        if (op_kind == OPK_STATUS) begin
          status <= {new_status[7:2], 2'b00};
        end
      end else begin
        op_cnt <= op_cnt - CNT_W'(1);
      end
    end else if (cmd_end && !sleeping) begin
      if (opcode == OP_WRITE_DISABLE && bytecnt == 6'd1) begin
        status[STAT_WEL] <= 1'b0;
      end else if (opcode == OP_WRITE_ENABLE && bytecnt == 6'd1 && write_ok) begin
        status[STAT_WEL] <= 1'b1;
      end else if (write_ok && status[STAT_WEL]) begin
        if (opcode == OP_STATUS_WRITE && bytecnt >= 6'd2) begin
          busy <= 1'b1;
          op_kind <= OPK_STATUS;
          new_status <= data_byte;
          op_cnt <= CNT_W'(STATUS_CYC - 1);
        end else if (opcode == OP_PAGE_PROG && bytecnt >= 6'd5) begin
          busy <= 1'b1;
          op_kind <= OPK_PROG;
          op_cnt <= CNT_W'(PROG_CYC - 1);
        end else if (opcode == OP_SECTOR_ERASE && bytecnt == 6'd4) begin
          busy <= 1'b1;
          op_kind <= OPK_ERASE;
          op_cnt <= CNT_W'(SECTOR_CYC - 1);
          er_ptr <= {addr[MEM_AW-1:SECTOR_AW], {SECTOR_AW{1'b0}}};
          er_last <= {addr[MEM_AW-1:SECTOR_AW], {SECTOR_AW{1'b1}}};
        end else if ((opcode == OP_BLOCK_ERASE_A || opcode == OP_BLOCK_ERASE_B) && bytecnt == 6'd4) begin
          busy <= 1'b1;
          op_kind <= OPK_ERASE;
          op_cnt <= CNT_W'(BLOCK_CYC - 1);
          er_ptr <= {addr[MEM_AW-1:BLOCK_AW], {BLOCK_AW{1'b0}}};
          er_last <= {addr[MEM_AW-1:BLOCK_AW], {BLOCK_AW{1'b1}}};
        end else if ((opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B) && bytecnt == 6'd1) begin
          busy <= 1'b1;
          op_kind <= OPK_ERASE;
          op_cnt <= CNT_W'(CHIP_CYC - 1);
          er_ptr <= '0;
          er_last <= '1;
        end
      end
    end
  end

  // ==========================================================
  // Array writes: program bytes land while select is low, gated by the write permission at each byte's arrival
  // Trade-off: a program whose timed cycle is refused can still leave bytes, since
  // writes are committed whenever the permission holds at byte arrival.
  wire prog_byte = byte_done & (opcode == OP_PAGE_PROG) & (bytecnt >= 6'd4) & write_ok & status[STAT_WEL];
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = er_ptr;
    mem_wdata = ERASED_BYTE;
    if (busy && op_kind == OPK_ERASE) begin
      mem_we = 1'b1;
    end else if (prog_byte) begin
      mem_we = 1'b1;
      mem_waddr = addr[MEM_AW-1:0] + MEM_AW'(bytecnt - 6'd4);
      mem_wdata = next_byte & 8'hFF;
    end
  end

  // ==========================================================
  // Read side
  logic [MEM_AW-1:0] rd_ptr;
  logic [7:0] rd_data, out_sh;
  logic id_sel;
  wire read_active = ~sel_n & ~sleeping & ~busy & (opcode == OP_READ) & (bytecnt >= 6'd4);
  always_ff @(posedge ref_clk) begin
    if (!resetn || sel_fall) begin
      rd_ptr <= '0;
      id_sel <= 1'b0;
    end else if (byte_done && bytecnt == 6'd3) begin
      rd_ptr <= next_byte[MEM_AW-1:0];
      id_sel <= (next_byte != ID_ADDR_MFR);
    end else if (byte_done && bytecnt >= 6'd4) begin
      rd_ptr <= rd_ptr + MEM_AW'(1);
      id_sel <= ~id_sel;
    end
  end
  // Shift register reloads on the falling edge that follows each byte boundary
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_sh <= 8'h00;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (sel_n) begin
      so_oe_n <= 1'b1;
    end else if (sck_fall) begin
      if (bitcnt == 3'd0) begin
        if (opcode == OP_READ && read_active) begin
          out_sh <= {rd_data[6:0], 1'b0};
          so <= rd_data[7];
          so_oe_n <= 1'b0;
        end else if (opcode == OP_ID_READ && bytecnt >= 6'd4 && !sleeping) begin
          out_sh <= id_sel ? {DEV_CODE[6:0], 1'b0} : {MFR_CODE[6:0], 1'b0};
          so <= id_sel ? DEV_CODE[7] : MFR_CODE[7];
          so_oe_n <= 1'b0;
        end else if (opcode == OP_STATUS_READ && bytecnt >= 6'd1 && !sleeping) begin
          // Busy shows in bit 0 while an operation runs
          out_sh <= {status[6:1], status[STAT_BUSY] | busy, 1'b0};
          so <= status[7];
          so_oe_n <= 1'b0;
        end else if (opcode == OP_WAKE_SIG && bytecnt >= 6'd4) begin
          out_sh <= {DEV_CODE[6:0], 1'b0};
          so <= DEV_CODE[7];
          so_oe_n <= 1'b0;
        end
      end else begin
        so <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  sflash_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(rd_ptr),
    .rd_data(rd_data)
  );
endmodule : sflash_cmd
`default_nettype wire

// ---- hdl/sflash_mem.sv ----
// Purpose: Small byte array with registered read data.
// Assumes: At most one write and one read per cycle.
// Notes: Erase walks addresses one per cycle from the controller.
`timescale 1ns/1ps
`default_nettype none
module sflash_mem (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [sflash_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [sflash_pkg::MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  import sflash_pkg::*;
  logic [7:0] cells [0:MEM_WORDS-1];

  // Erased contents as shipped
  initial begin
    for (int i = 0; i < MEM_WORDS; i++) begin
      cells[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end
endmodule : sflash_mem
`default_nettype wire

// ---- hdl/sflash_pkg.sv ----
// Purpose: Constants for the serial flash command decoder.
// Assumes: 20 MHz ref_clk; serial link sampled as ordinary inputs.
// Notes: Array is modelled small; opcodes and times as documented.
package sflash_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned MEM_AW = 8;
  localparam int unsigned MEM_WORDS = 256;
  localparam int unsigned SECTOR_AW = 4;
  localparam int unsigned BLOCK_AW = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_WEL = 1;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_B = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIG = 8'hAB;
  localparam logic [7:0] OP_ID_READ = 8'h90;
  localparam logic [7:0] ID_ADDR_MFR = 8'h00;
  localparam logic [7:0] ID_ADDR_DEV = 8'h01;
  // Times in their own units
  localparam int unsigned WRITE_LOCKOUT_MAX_MS = 10;
  localparam int unsigned STATUS_WRITE_TIME_MS = 15;
  localparam int unsigned PAGE_PROGRAM_TIME_MS = 5;
  localparam int unsigned SECTOR_ERASE_TIME_MS = 120;
  localparam int unsigned BLOCK_ERASE_TIME_MS = 2000;
  localparam int unsigned CHIP_ERASE_TIME_MS = 7500;
  localparam int unsigned SLEEP_ENTRY_TIME_US = 3;
  localparam int unsigned WAKE_TIME_US = 3;
  // Longest times round down to cycles
  localparam int unsigned WRITE_LOCKOUT_CYC = WRITE_LOCKOUT_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned STATUS_WRITE_CYC = STATUS_WRITE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SLEEP_ENTRY_CYC = SLEEP_ENTRY_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned WAKE_CYC = WAKE_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 28;
  typedef enum logic [1:0] {
    OPK_PROG,
    OPK_ERASE,
    OPK_STATUS
  } op_kind_t;
endpackage : sflash_pkg

// ---- tb/sflash_cmd_monitor.sv ----
// Purpose: Port-level checks for the flash command decoder.
// Assumes: One clock domain; reset synchronous, active low.
// Notes: Times are in ref_clk cycles; sync delay allowed.
`timescale 1ns/1ps
`default_nettype none
module sflash_cmd_monitor #(
  parameter int unsigned LOCKOUT_CYC = 20,
  parameter int unsigned PROG_CYC = 20,
  parameter int unsigned CHIP_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic busy,
  input wire logic sleeping,
  input wire logic lockout
);
  int unsigned since_rel;
  int unsigned busy_len;
  int unsigned cs_hi;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ===
  // Helper counters
  always_ff @(posedge ref_clk) begin
    if (!resetn) since_rel <= 0;
    else if (since_rel < LOCKOUT_CYC + 8) since_rel <= since_rel + 1;
  end
  always_ff @(posedge ref_clk) begin
    if (!busy) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end
  // Saturates so a long idle cannot wrap
  always_ff @(posedge ref_clk) begin
    if (!cs_n) cs_hi <= 0;
    else if (cs_hi < 1000) cs_hi <= cs_hi + 1;
  end
  // ===
  // Checks
  chk_reset_state: assert property ($rose(resetn) |-> lockout && !busy && !sleeping && so_oe_n)
    else $error("outputs wrong at reset release");
  chk_lockout_min: assert property ($fell(lockout) |-> since_rel >= LOCKOUT_CYC - 2)
    else $error("lockout ended early");
  chk_lockout_max: assert property (lockout |-> since_rel <= LOCKOUT_CYC + 2)
    else $error("lockout lasted too long");
  chk_lock_no_op: assert property (lockout |-> !busy)
    else $error("operation started during lockout");
  chk_busy_start: assert property ($rose(busy) |-> cs_n && $past(cs_n, 3) && !sleeping)
    else $error("busy rose outside a deselect");
  chk_busy_bounds: assert property ($fell(busy) |-> busy_len >= PROG_CYC - 2 && busy_len <= CHIP_CYC + 2)
    else $error("busy length out of range");
  chk_sleep_entry: assert property ($rose(sleeping) |-> cs_n && cs_hi <= 61 && !busy)
    else $error("power-down entry late");
  chk_wake_time: assert property ($fell(sleeping) |-> cs_n && cs_hi <= 61)
    else $error("wake late");
  chk_sleep_quiet: assert property (sleeping |-> !busy)
    else $error("busy while asleep");
  chk_oe_idle: assert property (cs_n [*5] |-> so_oe_n)
    else $error("output driven while deselected");
endmodule : sflash_cmd_monitor
bind sflash_cmd sflash_cmd_monitor #(.LOCKOUT_CYC(LOCKOUT_CYC), .PROG_CYC(PROG_CYC), .CHIP_CYC(CHIP_CYC))
  sflash_cmd_monitor_i (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .so_oe_n(so_oe_n), .busy(busy),
  .sleeping(sleeping), .lockout(lockout));
`default_nettype wire

// ---- tb/sflash_cmd_tb.sv ----
// Purpose: Self-checking bench for the flash command decoder.
// Assumes: Shortened op times through parameters.
// Notes: Seeded random addresses and data.
`timescale 1ns/1ps
`default_nettype none
module sflash_cmd_tb;
  import sflash_pkg::*;
  localparam int T_LOCK = 2000;
  localparam int T_STAT = 1000;
  localparam int T_PROG = 400;
  localparam int T_SEC = 1200;
  localparam int T_BLK = 1400;
  localparam int T_CHIP = 1600;
  localparam logic [7:0] ID_M = 8'h5A; // Arbitrary
  localparam logic [7:0] ID_D = 8'h96; // Arbitrary
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n, sclk, si, so, so_oe_n, busy, sleeping, lockout;
  logic [7:0] r [0:7];
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] eop [0:4] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  int etm [0:4] = '{T_SEC, T_BLK, T_BLK, T_CHIP, T_CHIP};
  int n_errors = 0;
  int checks = 0;
  int seed = 37560;
  int k;
  sflash_cmd #(.LOCKOUT_CYC(T_LOCK), .STATUS_CYC(T_STAT), .PROG_CYC(T_PROG), .SECTOR_CYC(T_SEC),
    .BLOCK_CYC(T_BLK), .CHIP_CYC(T_CHIP), .MFR_CODE(ID_M), .DEV_CODE(ID_D)) sflash_cmd_i (.ref_clk(ref_clk),
    .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n), .busy(busy),
    .sleeping(sleeping), .lockout(lockout));
  sflash_host sflash_host_i (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ===
  // Tasks
  task automatic complete_run();
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(input logic [47:0] v, input int n);
    for (int i = 0; i < 6; i++) sflash_host_i.txb[i] = v[47-8*i -: 8];
    sflash_host_i.frame(n);
    r = sflash_host_i.rxb;
  endtask : send
  task automatic wren();
    send({OP_WRITE_ENABLE, 40'h0}, 1);
  endtask : wren
  // Busy must last t cycles, less at most slack, within sync delay
  task automatic wait_busy(input string what, input int t, input int slack);
    int n;
    n = 0;
    repeat (4) @(negedge ref_clk);
    while (busy === 1'b1 && n < t + 50) begin
      @(negedge ref_clk);
      n++;
    end
    check(what, {7'd0, n <= t + 4 && n + slack >= t}, 8'd1);
    if (n >= t + 50) complete_run();
  endtask : wait_busy
  // ===
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 resetn = 1'b1;
    check("lockout", {7'd0, lockout}, 8'd1);
    repeat (4) @(posedge ref_clk);
    wren();
    send({OP_SECTOR_ERASE, 40'h0}, 4);
    wait_busy("locked_erase", 0, 12);
    send({OP_STATUS_READ, 40'h0}, 2);
    check("status_init", r[1], STATUS_RESET);
    k = 0;
    while (lockout === 1'b1 && k < T_LOCK) begin
      @(negedge ref_clk);
      k++;
    end
    check("lockout_end", {7'd0, lockout}, 8'd0);
    if (k >= T_LOCK) complete_run();
    for (k = 0; k < 4; k++) begin
      a = 8'($random(seed));
      send({OP_READ, 16'h0, a, 16'h0}, 6);
      check("erased", r[4], ERASED_BYTE);
      check("stream", r[5], ERASED_BYTE);
    end
    for (k = 0; k < 5; k++) begin
      a = 8'($random(seed));
      d = {1'b0, 7'($random(seed))};
      wren();
      send({OP_PAGE_PROG, 16'h0, a, d, 8'h0}, 5);
      wait_busy("program", T_PROG, 12);
      send({OP_READ, 16'h0, a, 16'h0}, 5);
      check("programmed", r[4], d);
      wren();
      send({eop[k], 16'h0, a, 16'h0}, k < 3 ? 4 : 1);
      wait_busy("erase", etm[k], 12);
      send({OP_READ, 16'h0, a, 16'h0}, 5);
      check("erased_again", r[4], ERASED_BYTE);
    end
    wren();
    send({OP_WRITE_DISABLE, 40'h0}, 1);
    send({OP_SECTOR_ERASE, 40'h0}, 4);
    wait_busy("disabled_erase", 0, 12);
    for (k = 0; k < 2; k++) begin
      send({OP_ID_READ, 16'h0, 8'(k), 16'h0}, 6);
      check("id_first", r[4], k ? ID_D : ID_M);
      check("id_next", r[5], k ? ID_M : ID_D);
    end
    send({OP_DEEP_SLEEP, 40'h0}, 1);
    repeat (70) @(negedge ref_clk);
    check("asleep", {7'd0, sleeping}, 8'd1);
    wren();
    send({OP_SECTOR_ERASE, 40'h0}, 4);
    wait_busy("sleep_erase", 0, 12);
    send({OP_WAKE_SIG, 40'h0}, 1);
    repeat (70) @(negedge ref_clk);
    check("awake", {7'd0, sleeping}, 8'd0);
    send({OP_WAKE_SIG, 40'h0}, 5);
    check("signature", r[4], ID_D);
    d = 8'($random(seed));
    wren();
    send({OP_STATUS_WRITE, d, 32'h0}, 2);
    wait_busy("status_write", T_STAT, 12);
    send({OP_STATUS_READ, 40'h0}, 2);
    check("status", r[1], {d[7:2], 2'b00});
    wren();
    send({OP_STATUS_WRITE, ~d, 32'h0}, 2);
    send({OP_STATUS_READ, 40'h0}, 2);
    check("busy_bit", {7'd0, r[1][STAT_BUSY]}, 8'd1);
    wren();
    send({OP_STATUS_WRITE, d, 32'h0}, 2);
    wait_busy("status_busy", T_STAT, T_STAT);
    send({OP_STATUS_READ, 40'h0}, 2);
    check("status_kept", r[1], {~d[7:2], 2'b00});
    complete_run();
  end
endmodule : sflash_cmd_tb
`default_nettype wire

// ---- tb/sflash_host.sv ----
// Purpose: Host bus master model for the flash link.
// Assumes: 20 MHz ref_clk; link clock 400 ns, mode 0.
// Notes: Link clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module sflash_host (
  input wire logic ref_clk,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  logic [7:0] txb [0:7];
  logic [7:0] rxb [0:7];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // ===
  // One frame of n bytes
  task automatic frame(input int n);
    @(posedge ref_clk);
    #1 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        si = txb[i][b];
        repeat (4) @(posedge ref_clk);
        #1 sclk = 1'b1;
        repeat (4) @(posedge ref_clk);
        // Read late in the high phase: the output only moves after a fall
        #1 rxb[i][b] = so;
        sclk = 1'b0;
      end
    end
    repeat (2) @(posedge ref_clk);
    #1 cs_n = 1'b1;
    // Released data line must not look held
    si = ~si;
    repeat (3) @(posedge ref_clk);
  endtask : frame
endmodule : sflash_host
`default_nettype wire
